// file: logic/tci_interlock.v
// What this block does
// - each channel ignores pulses and dropouts of up to 1 ms.
// - a de-energized channel requests torque cutoff, energized permits running.
// - when the inputs de-energize the gate-drive enable is withdrawn.
// - a mode setting picks the indication, also by run or stop state at the event.
// - the mode setting has no effect on the cutoff path itself.
// - a running drive stops when either channel or both are removed.
// - start is blocked until both channels are energized and all faults are reset.
// - loss of exactly one channel for more than 200 ms raises a fault whatever the mode.
// - after restoration a reset is needed or not depending on the mode setting.
// - restoring the channels never restarts the drive; a fresh start is needed.
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`include "tci_defs.vh"

module tci_interlock #(
    parameter [23:0] FILT_CYC = `TCI_FILT_CYC,
    parameter [23:0] DISC_CYC = `TCI_DISC_CYC
) (
    input wire clk_sys,
    input wire rstn,
    // safety input pins, asynchronous to clk_sys
    input wire cutoff_channel_a,
    input wire cutoff_channel_b,
    // register bus, axi4-lite
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    // drive enable and status levels
    output wire gate_drive_en,
    output wire ch_a_ok,
    output wire ch_b_ok,
    output wire single_fault,
    output wire cutoff_active,
    output wire fault_ind,
    output wire warn_ind,
    output wire drive_running
);

    // run/stop states, one-hot
    localparam [1:0] ST_STOP = 2'b01;
    localparam [1:0] ST_RUN = 2'b10;

    // true for the three mapped offsets
    function addr_ok;
        input [3:0] a;
        begin
            addr_ok = (a == `TCI_ADDR_CTRL) || (a == `TCI_ADDR_CFG) ||
                (a == `TCI_ADDR_STAT);
        end
    endfunction

    // indication kind for a cutoff event: bit 1 fault, bit 0 warning
    // mode 3 gives no event indication, only single_q can still fault; the cutoff itself still acts
    function [1:0] ind_kind;
        input [1:0] mode;
        input running;
        begin
            case (mode)
                `TCI_MODE_FAULT: ind_kind = 2'h2;
                `TCI_MODE_MIXED: ind_kind = running ? 2'h2 : 2'h1;
                `TCI_MODE_WARN: ind_kind = 2'h1;
                default: ind_kind = 2'h0;
            endcase
        end
    endfunction

    // input path: synchronizer, glitch filter, skew timer
    reg [1:0] sync1_q;
    reg [1:0] sync2_q;
    reg [1:0] filt_q;
    reg [23:0] fcnt_q [0:1];
    reg [23:0] dcnt_q;
    reg single_q;

    // indication latches, run state and mode
    reg cut_prev_q;
    reg cutflt_q;
    reg warn_q;
    reg [1:0] state_q;
    reg [1:0] mode_q;

    // bus side: held halves of a write, answers
    reg aw_held_q;
    reg [3:0] aw_addr_q;
    reg w_held_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    reg bvalid_q;
    reg [1:0] bresp_q;
    reg rvalid_q;
    reg [31:0] rdata_q;
    reg [1:0] rresp_q;
    // loop index of the per-channel filter
    integer i;

    // cutoff decode and one-cycle command pulses
    wire cut;
    wire cut_event;
    wire [1:0] kind;
    wire do_wr;
    wire ctrl_wr;
    wire cmd_start;
    wire cmd_stop;
    wire cmd_reset;
    wire start_ok;
    wire [7:0] status;

    // two flops per channel; only the second stage is read
    // pins are asynchronous, so nothing else may look at sync1_q
    // reset holds both stages de-energized, never a false run level
    always @(posedge clk_sys) begin
        if (!rstn) begin
            sync1_q <= 2'h0;
            sync2_q <= 2'h0;
        end else begin
            sync1_q <= {cutoff_channel_b, cutoff_channel_a};
            sync2_q <= sync1_q;
        end
    end

    // glitch filter: flips only after more than FILT_CYC differing cycles
    // reset state is de-energized so the drive powers up in cutoff
    // a dropout of exactly FILT_CYC synced cycles leaves filt_q alone
    // limitation: a real cutoff reaches the gate about FILT_CYC+3 cycles late
    always @(posedge clk_sys) begin
        if (!rstn) begin
            filt_q <= 2'h0;
            fcnt_q[0] <= 24'h0;
            fcnt_q[1] <= 24'h0;
        end else begin
            for (i = 0; i < 2; i = i + 1) begin
                if (sync2_q[i] == filt_q[i]) begin
                    fcnt_q[i] <= 24'h0;
                end else if (fcnt_q[i] >= FILT_CYC) begin
                    filt_q[i] <= sync2_q[i];
                    fcnt_q[i] <= 24'h0;
                end else begin
                    fcnt_q[i] <= fcnt_q[i] + 24'h1;
                end
            end
        end
    end

    // either channel low means cutoff; mode is deliberately absent here
    assign cut = ~filt_q[0] | ~filt_q[1];
    // first cycle of a cutoff only
    assign cut_event = cut & ~cut_prev_q;
    // run state at the event picks the kind
    assign kind = ind_kind(mode_q, state_q == ST_RUN);

    // channel mismatch longer than the contact skew window is a wiring fault
    // the counter saturates at DISC_CYC so a long mismatch never wraps
    // the fault stays until a reset arrives with both channels up
    always @(posedge clk_sys) begin
        if (!rstn) begin
            dcnt_q <= 24'h0;
            single_q <= 1'b0;
        end else begin
            if (filt_q[0] == filt_q[1]) begin
                dcnt_q <= 24'h0;
            end else if (dcnt_q < DISC_CYC) begin
                dcnt_q <= dcnt_q + 24'h1;
            end
            if ((filt_q[0] != filt_q[1]) && (dcnt_q >= DISC_CYC)) begin
                single_q <= 1'b1;
            end else if (cmd_reset && !cut) begin
                single_q <= 1'b0;
            end
        end
    end

    // indication latches; set on the cutoff edge wins over a reset
    // the edge detector starts high: reset leaves the channels de-energized,
    // so power-up is not taken as a cutoff event needing a reset
    // warnings clear by themselves once both channels are back
    always @(posedge clk_sys) begin
        if (!rstn) begin
            cut_prev_q <= 1'b1;
            cutflt_q <= 1'b0;
            warn_q <= 1'b0;
        end else begin
            cut_prev_q <= cut;
            if (cut_event && kind[1]) begin
                cutflt_q <= 1'b1;
            end else if (cmd_reset && !cut) begin
                cutflt_q <= 1'b0;
            end
            if (cut_event && kind[0]) begin
                warn_q <= 1'b1;
            end else if (!cut) begin
                warn_q <= 1'b0;
            end
        end
    end

    // start only from stop, with channels up and no fault pending;
    // a start pulse during cutoff is dropped, never remembered
    // faults latched while stopped block start like running ones
    assign start_ok = !cut && !single_q && !cutflt_q;

    // run/stop state machine
    // mode_q is not read here: cutoff acts the same in every mode
    // software stop is honoured in run only
    always @(posedge clk_sys) begin
        if (!rstn) begin
            state_q <= ST_STOP;
        end else begin
            case (state_q)
                ST_STOP: begin
                    if (cmd_start && start_ok) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (cut || cmd_stop) begin
                        state_q <= ST_STOP;
                    end
                end
                default: state_q <= ST_STOP;
            endcase
        end
    end

    // gated by cut directly so removal acts without waiting for the fsm
    // the fsm still drops to stop, so restoration alone cannot resume
    assign gate_drive_en = (state_q == ST_RUN) && !cut;

    // status outputs from flops; cutoff_active and fault_ind pass through one OR gate, drive_running through a state_q compare
    assign ch_a_ok = filt_q[0];
    assign ch_b_ok = filt_q[1];
    assign single_fault = single_q;
    assign cutoff_active = cut;
    // one-channel loss longer than DISC_CYC shows as a fault in every mode
    assign fault_ind = cutflt_q | single_q;
    assign warn_ind = warn_q;
    assign drive_running = (state_q == ST_RUN);

    // status word for the bus, bit 7 is the start permission
    assign status = {start_ok, drive_running, warn_q, cutflt_q, single_q, cut,
        filt_q[1], filt_q[0]};

    // write channel: address and data taken in either order
    // each half waits in its holding flop until the other arrives
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready = !w_held_q && !bvalid_q;
    assign do_wr = aw_held_q && w_held_q;
    // command bits act only in the one do_wr cycle, so they never repeat
    // only byte lane 0 is decoded; the upper lanes are ignored
    assign ctrl_wr = do_wr && (aw_addr_q == `TCI_ADDR_CTRL) && w_strb_q[0];
    assign cmd_start = ctrl_wr && w_data_q[`TCI_CTRL_START];
    assign cmd_stop = ctrl_wr && w_data_q[`TCI_CTRL_STOP];
    assign cmd_reset = ctrl_wr && w_data_q[`TCI_CTRL_RESET];

    // write side registers; bvalid holds until bready is seen
    always @(posedge clk_sys) begin
        if (!rstn) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 4'h0;
            w_held_q <= 1'b0;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= `TCI_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= addr_ok(aw_addr_q) ? `TCI_RESP_OKAY : `TCI_RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // write answer straight from flops
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // config register, byte lane 0 only, updated with the write answer
    always @(posedge clk_sys) begin
        if (!rstn) begin
            mode_q <= `TCI_CFG_MODE_RST;
        end else if (do_wr && (aw_addr_q == `TCI_ADDR_CFG) && w_strb_q[0]) begin
            mode_q <= w_data_q[`TCI_CFG_MODE_LSB +: 2];
        end
    end

    // read channel: one read in flight, data registered at the handshake
    // ctrl reads back as zero since its bits are pulses
    // unmapped offsets answer slverr with zero data
    assign s_axi_arready = !rvalid_q;

    always @(posedge clk_sys) begin
        if (!rstn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= `TCI_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= addr_ok(s_axi_araddr) ? `TCI_RESP_OKAY : `TCI_RESP_SLVERR;
            case (s_axi_araddr)
                `TCI_ADDR_CFG: rdata_q <= {30'h0, mode_q};
                `TCI_ADDR_STAT: rdata_q <= {24'h0, status};
                default: rdata_q <= 32'h0;
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // read answer straight from flops
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

endmodule

// file: pkg/tci_defs.vh
`ifndef TCI_DEFS_VH
`define TCI_DEFS_VH

// clock rate and the timing figures, in their own units
`define TCI_CLK_KHZ 10000
`define TCI_FILT_TIME_US 1000
`define TCI_DISC_TIME_MS 200
// cycle counts derived from the figures above
`define TCI_FILT_CYC (`TCI_FILT_TIME_US * `TCI_CLK_KHZ / 1000)
`define TCI_DISC_CYC (`TCI_DISC_TIME_MS * `TCI_CLK_KHZ)

// register byte offsets
`define TCI_ADDR_CTRL 4'h0
`define TCI_ADDR_CFG 4'h4
`define TCI_ADDR_STAT 4'h8

// control register, write-one pulses
`define TCI_CTRL_START 0
`define TCI_CTRL_STOP 1
`define TCI_CTRL_RESET 2

// config register: indication mode field
`define TCI_CFG_MODE_LSB 0
`define TCI_CFG_MODE_RST 2'h1
`define TCI_MODE_FAULT 2'h0
`define TCI_MODE_MIXED 2'h1
`define TCI_MODE_WARN 2'h2
`define TCI_MODE_NONE 2'h3

// status register bit positions
`define TCI_ST_CH_A 0
`define TCI_ST_CH_B 1
`define TCI_ST_CUT 2
`define TCI_ST_SINGLE 3
`define TCI_ST_CUTFLT 4
`define TCI_ST_WARN 5
`define TCI_ST_RUN 6
`define TCI_ST_START_OK 7

// bus responses
`define TCI_RESP_OKAY 2'h0
`define TCI_RESP_SLVERR 2'h2

`endif

// file: tb/tci_checker.sv
module tci_checker #(
    parameter [23:0] FILT_CYC = 24'h8,
    parameter [23:0] DISC_CYC = 24'h28
) (
    input wire clk_sys,
    input wire rstn,
    input wire cutoff_channel_a,
    input wire cutoff_channel_b,
    input wire s_axi_bvalid,
    input wire gate_drive_en,
    input wire ch_a_ok,
    input wire ch_b_ok,
    input wire single_fault,
    input wire cutoff_active,
    input wire fault_ind,
    input wire drive_running
);
    logic [23:0] hi_q, lo_q, diff_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // run lengths of raw pin levels and of filtered disagreement
    always @(posedge clk_sys) begin
        hi_q <= (rstn && cutoff_channel_a) ? hi_q + 24'h1 : 24'h0;
        lo_q <= (rstn && !cutoff_channel_b) ? lo_q + 24'h1 : 24'h0;
        diff_q <= (ch_a_ok != ch_b_ok) ? diff_q + 24'h1 : 24'h0;
    end
    property p_cut; cutoff_active == (!ch_a_ok || !ch_b_ok); endproperty
    a_cut: assert property (p_cut) else $error("cutoff state wrong");
    property p_gate; gate_drive_en == (drive_running && !cutoff_active); endproperty
    a_gate: assert property (p_gate) else $error("gate enable wrong");
    property p_stop; cutoff_active |=> !drive_running; endproperty
    a_stop: assert property (p_stop) else $error("drive kept running");
    property p_filt_a; $rose(ch_a_ok) |-> hi_q > FILT_CYC; endproperty
    a_filt_a: assert property (p_filt_a) else $error("channel a rose early");
    property p_filt_b; $fell(ch_b_ok) |-> lo_q > FILT_CYC; endproperty
    a_filt_b: assert property (p_filt_b) else $error("channel b fell early");
    property p_single; diff_q == DISC_CYC + 24'h1 |-> single_fault; endproperty
    a_single: assert property (p_single) else $error("one-channel loss missed");
    property p_flt; single_fault |-> fault_ind; endproperty
    a_flt: assert property (p_flt) else $error("fault not indicated");
    property p_fresh; $rose(drive_running) |-> s_axi_bvalid || $past(s_axi_bvalid); endproperty
    a_fresh: assert property (p_fresh) else $error("run without command");
    property p_block; $rose(drive_running) |-> !$past(cutoff_active) && !$past(single_fault);
    endproperty
    a_block: assert property (p_block) else $error("start not blocked");
    c_run: cover property ($rose(drive_running));
    c_cut: cover property ($rose(cutoff_active) && drive_running);
    c_single: cover property ($rose(single_fault));
endmodule

bind tci_interlock tci_checker #(.FILT_CYC(FILT_CYC), .DISC_CYC(DISC_CYC)) u_chk (
    .clk_sys(clk_sys), .rstn(rstn), .cutoff_channel_a(cutoff_channel_a),
    .cutoff_channel_b(cutoff_channel_b), .s_axi_bvalid(s_axi_bvalid),
    .gate_drive_en(gate_drive_en), .ch_a_ok(ch_a_ok), .ch_b_ok(ch_b_ok),
    .single_fault(single_fault), .cutoff_active(cutoff_active), .fault_ind(fault_ind),
    .drive_running(drive_running)
);

// file: tb/tci_contacts.sv
module tci_contacts (
    input wire clk_sys,
    input wire open_cmd,
    input wire jam_b,
    input wire dip_a,
    input wire [7:0] skew,
    output logic cutoff_channel_a,
    output logic cutoff_channel_b
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] lag_q;
    initial begin
        cutoff_channel_a = 1'b1;
        cutoff_channel_b = 1'b1;
        lag_q = 8'h0;
    end
    // one command moves both contacts; b lags, a jammed b is a wiring fault
    always @(posedge clk_sys) begin
        cutoff_channel_a <= !open_cmd && !dip_a;
        if (jam_b || cutoff_channel_b == !open_cmd) lag_q <= 8'h0;
        else if (lag_q >= skew) cutoff_channel_b <= !open_cmd;
        else lag_q <= lag_q + 8'h1;
    end
endmodule

// file: tb/testbench.sv
`include "tci_defs.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int F = 8;
    localparam int D = 40;
    logic clk_sys = 1'b0, rstn = 1'b0, awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0;
    logic rrd = 1'b0, opn = 1'b0, jam = 1'b0, dip = 1'b0, fe, we;
    logic [3:0] awa = 4'h0, ara = 4'h0;
    logic [7:0] skew = 8'h0;
    logic [31:0] wd = 32'h0, rnd;
    logic [65:0] ent;
    logic [65:0] rq[$];
    logic [1:0] bq[$];
    wire awr, wrdy, bv, arr, rv, ca, cb, gate, cha, chb, sgl, cut, flt, wrn, run;
    wire [1:0] br, rsp;
    wire [31:0] rd;
    int fails = 0, check_count = 0, m, r;

    always #50 clk_sys = ~clk_sys;
    tci_contacts u_sw (.clk_sys(clk_sys), .open_cmd(opn), .jam_b(jam), .dip_a(dip),
        .skew(skew), .cutoff_channel_a(ca), .cutoff_channel_b(cb));
    tci_interlock #(.FILT_CYC(24'(F)), .DISC_CYC(24'(D))) dut (.clk_sys(clk_sys), .rstn(rstn),
        .cutoff_channel_a(ca), .cutoff_channel_b(cb), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brd),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rsp), .s_axi_rvalid(rv), .s_axi_rready(rrd), .gate_drive_en(gate),
        .ch_a_ok(cha), .ch_b_ok(chb), .single_fault(sgl), .cutoff_active(cut),
        .fault_ind(flt), .warn_ind(wrn), .drive_running(run));

    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // both halves offered together, each dropped when taken; bready stays up
    task automatic wr(input [3:0] a, input [31:0] d, input [1:0] e);
        logic aw_p;
        logic w_p;
        aw_p = 1'b1;
        w_p = 1'b1;
        bq.push_back(e);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        brd <= 1'b1;
        while (aw_p || w_p) begin
            @(posedge clk_sys);
            if (aw_p && awr) begin
                awv <= 1'b0;
                aw_p = 1'b0;
            end
            if (w_p && wrdy) begin
                wv <= 1'b0;
                w_p = 1'b0;
            end
        end
        do @(posedge clk_sys); while (!bv);
    endtask
    task automatic rdc(input [3:0] a, input [31:0] e, input [31:0] k, input [1:0] er);
        rq.push_back({k, e, er});
        ara <= a;
        arv <= 1'b1;
        rrd <= 1'b1;
        do @(posedge clk_sys); while (!arr);
        arv <= 1'b0;
        do @(posedge clk_sys); while (!rv);
    endtask
    task automatic cmd(input int b);
        wr(`TCI_ADDR_CTRL, 32'h1 << b, `TCI_RESP_OKAY);
        @(posedge clk_sys);
    endtask
    // bounded wait for the cutoff state, then let latches land
    task automatic settle(input logic want);
        int i;
        for (i = 0; i < 300 && cut !== want; i++) @(posedge clk_sys);
        repeat (2) @(posedge clk_sys);
    endtask

    // answers are matched oldest first against the notes
    always @(posedge clk_sys) begin
        if (bv && brd) check("bresp", 32'(br), 32'(bq.pop_front()));
        if (rv && rrd) begin
            ent = rq.pop_front();
            check("rdata", rd & ent[65:34], ent[33:2]);
            check("rresp", 32'(rsp), 32'(ent[1:0]));
        end
    end

    initial begin
        repeat (30000) @(posedge clk_sys);
        fails++;
        tally_and_finish();
    end

    initial begin
        rnd = $urandom(32'hc476);
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        rdc(`TCI_ADDR_CFG, 32'h1, 32'h3, `TCI_RESP_OKAY);
        rdc(`TCI_ADDR_CTRL, 32'h0, 32'hffffffff, `TCI_RESP_OKAY);
        rdc(4'hc, 32'h0, 32'hffffffff, `TCI_RESP_SLVERR);
        wr(4'hc, rnd, `TCI_RESP_SLVERR);
        settle(1'b0);
        rdc(`TCI_ADDR_STAT, 32'h3, 32'h7f, `TCI_RESP_OKAY);
        // a dropout as long as the filter window must pass unseen
        cmd(`TCI_CTRL_START);
        dip <= 1'b1;
        repeat (F) @(posedge clk_sys);
        dip <= 1'b0;
        repeat (F + 6) @(posedge clk_sys);
        check("gate", gate, 1);
        cmd(`TCI_CTRL_STOP);
        for (r = 0; r < 2; r++) begin
            for (m = 0; m < 4; m++) begin
                rnd = $urandom;
                fe = (m == 0) || (m == 1 && r == 1);
                we = (m == 2) || (m == 1 && r == 0);
                wr(`TCI_ADDR_CFG, {rnd[31:2], 2'(m)}, `TCI_RESP_OKAY);
                rdc(`TCI_ADDR_CFG, 32'(m), 32'h3, `TCI_RESP_OKAY);
                if (r == 1) cmd(`TCI_CTRL_START);
                skew <= {3'h0, rnd[6:2]};
                opn <= 1'b1;
                settle(1'b1);
                check("gate", gate, 0);
                check("run", run, 0);
                check("fault", flt, 32'(fe));
                check("warn", wrn, 32'(we));
                repeat (D) @(posedge clk_sys);
                cmd(`TCI_CTRL_START);
                check("run", run, 0);
                opn <= 1'b0;
                settle(1'b0);
                check("run", run, 0);
                check("warn", wrn, 0);
                cmd(`TCI_CTRL_START);
                check("run", run, 32'(!fe));
                cmd(`TCI_CTRL_RESET);
                cmd(`TCI_CTRL_START);
                check("run", run, 1);
                cmd(`TCI_CTRL_STOP);
            end
        end
        // one contact stuck closed: loss of one channel only
        cmd(`TCI_CTRL_START);
        jam <= 1'b1;
        opn <= 1'b1;
        settle(1'b1);
        check("gate", gate, 0);
        repeat (D + 10) @(posedge clk_sys);
        check("fault", flt, 1);
        check("ch_a", cha, 0);
        check("ch_b", chb, 1);
        check("cut", cut, 1);
        rdc(`TCI_ADDR_STAT, 32'h0e, 32'h7f, `TCI_RESP_OKAY);
        opn <= 1'b0;
        jam <= 1'b0;
        settle(1'b0);
        cmd(`TCI_CTRL_START);
        check("run", run, 0);
        cmd(`TCI_CTRL_RESET);
        cmd(`TCI_CTRL_START);
        check("run", run, 1);
        check("single", sgl, 0);
        tally_and_finish();
    end
endmodule
